// File: pkg/spi_defines.svh
// constants for the spi port: timing floor, word lengths, reset values
`ifndef SPI_DEFINES_SVH
`define SPI_DEFINES_SVH
// fastest serial clock is clk/4, i.e. a half period of two cycles
`define SPI_MIN_HALF 16'h0002
// index of the last serial clock edge of a word (two edges per bit)
`define SPI_LAST_EDGE8 5'h0F
`define SPI_LAST_EDGE16 5'h1F
// word shifted out by a slave that has nothing queued
`define SPI_ZERO_WORD 16'h0000
// descriptors live in this page of peripheral i/o space
`define SPI_DMA_PAGE 8'h00
`define SPI_DIV_RESET 16'h0000
`define SPI_COUNT_RESET 16'h0000
`define SPI_SEL_RESET 7'h00
`endif

// File: pkg/spi_pkg.sv
// types shared by the spi port modules
package spi_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_master = 3'b010,
    st_slave = 3'b100
  } state_type;
endpackage : spi_pkg

// File: verilog/spi_word_buffer.sv
// two-entry valid/ready buffer for received words
`timescale 1ns/1ps
module spi_word_buffer (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [15:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [15:0] out_data
);
  logic [15:0] mem [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem[0] <= 16'h0000;
      mem[1] <= 16'h0000;
    end else if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  a_no_overfill: assert property (@(posedge clk) disable iff (rst)
    count == 2'h2 && !pop |=> count == 2'h2)
    else $error("buffer lost a word while full");
endmodule : spi_word_buffer

// File: verilog/spi_port.sv
// spi port: master or slave, 8/16-bit full duplex, modes 0-3, dma count
`timescale 1ns/1ps
`include "spi_defines.svh"
module spi_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic master_mode,
  input wire logic word16,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic broadcast,
  input wire logic [15:0] baud_div,
  input wire logic [6:0] select_mask,
  input wire logic dma_enable,
  input wire logic dma_load,
  input wire logic [15:0] dma_load_value,
  output logic [15:0] dma_count,
  output logic [7:0] dma_page,
  input wire logic [15:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [15:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic word_event,
  output logic dma_event,
  output logic overrun_event,
  output logic busy,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic slave_select_in_n,
  output logic [6:0] slave_select_out_n
);
  spi_pkg::state_type state;
  logic [15:0] div_cnt;
  logic [15:0] half;
  logic [4:0] edge_cnt;
  logic [4:0] last_edge;
  logic [15:0] shift_tx;
  logic [15:0] shift_rx;
  logic [15:0] next_rx;
  logic [15:0] rx_word;
  logic [6:0] sel_reg;
  logic [6:0] next_sel;
  logic sck_level;
  logic sck_s1, sck_s2, sck_s3;
  logic mosi_s1, mosi_s2;
  logic miso_s1, miso_s2;
  logic ss_s1, ss_s2;
  logic slave_sel;
  logic tick, lead, sample, launch, word_done, din;
  logic start_master, start_slave, load_word;
  logic dma_ok, dma_step;
  logic buf_in_ready;

  // every pin input is brought into clk through two flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
    end else begin
      sck_s1 <= sck_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      mosi_s1 <= mosi_in;
      mosi_s2 <= mosi_s1;
      miso_s1 <= miso_in;
      miso_s2 <= miso_s1;
      ss_s1 <= slave_select_in_n;
      ss_s2 <= ss_s1;
    end
  end

  // divider floor keeps sck at or below clk/4
  assign half = (baud_div < `SPI_MIN_HALF) ? `SPI_MIN_HALF : baud_div;
  // word length picks the edge count
  assign last_edge = word16 ? `SPI_LAST_EDGE16 : `SPI_LAST_EDGE8;
  // select input on flag pin zero, active low
  assign slave_sel = enable && !master_mode && !ss_s2;

  // dma word count gates new master words
  assign dma_ok = !dma_enable || (dma_count != 16'h0000);
  // no start until a slave select output is driven
  assign start_master = (state == spi_pkg::st_idle) && enable &&
    master_mode && (sel_reg != 7'h00) && tx_valid && dma_ok &&
    buf_in_ready;
  assign start_slave = (state == spi_pkg::st_idle) && slave_sel;

  always_comb begin
    tick = 1'b0;
    din = miso_s2;
    if (state == spi_pkg::st_master) begin
      tick = (div_cnt == half - 16'h0001);
    end else if (state == spi_pkg::st_slave) begin
      tick = (sck_s2 != sck_s3);
      din = mosi_s2;
    end
  end

  // even edges lead; phase chooses launch versus sample
  assign lead = !edge_cnt[0];
  assign sample = tick && (cpha ? !lead : lead);
  assign launch = tick && (cpha ? (lead && edge_cnt != 5'h00) : !lead);
  assign word_done = tick && (edge_cnt == last_edge);
  // back-to-back slave words reload while still selected
  assign load_word = start_master || start_slave ||
    (word_done && state == spi_pkg::st_slave && slave_sel);
  assign tx_ready = load_word;

  // sampled bit joins the receive word on the same edge set
  assign next_rx = sample ? {shift_rx[14:0], din} : shift_rx;
  assign rx_word = word16 ? next_rx : {8'h00, next_rx[7:0]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= spi_pkg::st_idle;
    end else begin
      unique case (state)
        spi_pkg::st_idle: begin
          if (start_master) begin
            state <= spi_pkg::st_master;
          end else if (start_slave) begin
            state <= spi_pkg::st_slave;
          end
        end
        spi_pkg::st_master: begin
          if (word_done || !enable) begin
            state <= spi_pkg::st_idle;
          end
        end
        spi_pkg::st_slave: begin
          // deselect mid-word abandons the partial word
          if (!slave_sel || (word_done && !slave_sel)) begin
            state <= spi_pkg::st_idle;
          end
        end
        default: begin
          state <= spi_pkg::st_idle;
        end
      endcase
    end
  end

  // divider paces master edges; sck_level is the unpolarised clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 16'h0000;
      sck_level <= 1'b0;
    end else if (state != spi_pkg::st_master) begin
      div_cnt <= 16'h0000;
      sck_level <= 1'b0;
    end else if (tick) begin
      div_cnt <= 16'h0000;
      sck_level <= ~sck_level;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edge_cnt <= 5'h00;
    end else if (load_word) begin
      edge_cnt <= 5'h00;
    end else if (tick) begin
      edge_cnt <= edge_cnt + 5'h01;
    end
  end

  // transmit word from the stream; zeros when none queued
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_tx <= `SPI_ZERO_WORD;
    end else if (load_word) begin
      if (tx_valid) begin
        shift_tx <= word16 ? tx_data : {tx_data[7:0], 8'h00};
      end else begin
        shift_tx <= `SPI_ZERO_WORD;
      end
    end else if (launch) begin
      shift_tx <= {shift_tx[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_rx <= 16'h0000;
    end else if (load_word) begin
      shift_rx <= 16'h0000;
    end else begin
      shift_rx <= next_rx;
    end
  end

  // broadcast keeps every chosen line; else only the lowest one
  always_comb begin
    next_sel = `SPI_SEL_RESET;
    if (enable && master_mode) begin
      next_sel = broadcast ? select_mask :
        (select_mask & (~select_mask + 7'h01));
    end
  end

  // select lines only move while no word is in flight
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_reg <= `SPI_SEL_RESET;
    end else if (state == spi_pkg::st_idle && !start_master) begin
      sel_reg <= next_sel;
    end
  end

  assign slave_select_out_n = ~sel_reg;

  // count steps down per word; reload queues more
  assign dma_step = word_done && dma_enable && (dma_count != 16'h0000);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_count <= `SPI_COUNT_RESET;
    end else if (dma_load) begin
      dma_count <= dma_load_value;
    end else if (dma_step) begin
      dma_count <= dma_count - 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_event <= 1'b0;
      dma_event <= 1'b0;
      overrun_event <= 1'b0;
    end else begin
      word_event <= word_done;
      dma_event <= dma_step && (dma_count == 16'h0001);
      overrun_event <= word_done && !buf_in_ready;
    end
  end

  // descriptor page is fixed at zero
  assign dma_page = `SPI_DMA_PAGE;
  assign busy = (state != spi_pkg::st_idle);

  // master owns sck and mosi; slave drives miso when selected
  assign sck_out = sck_level ^ cpol;
  assign sck_oe = enable && master_mode;
  assign mosi_out = word16 ? shift_tx[15] : shift_tx[15];
  assign mosi_oe = enable && master_mode;
  assign miso_out = shift_tx[15];
  assign miso_oe = slave_sel;

  // receiver cannot stall a remote master, so slave words may overrun
  spi_word_buffer rx_buffer (
    .clk(clk),
    .rst(rst),
    .in_valid(word_done),
    .in_ready(buf_in_ready),
    .in_data(rx_word),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // helper: sck toggles seen in the current master word
  logic [5:0] toggles;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      toggles <= 6'h00;
    end else if (start_master) begin
      toggles <= 6'h00;
    end else if (state == spi_pkg::st_master && tick) begin
      toggles <= toggles + 6'h01;
    end
  end

  sequence word_begins;
    start_master;
  endsequence
  sequence word_ends;
    state == spi_pkg::st_master && word_done;
  endsequence

  a_idle_sck_level: assert property (@(posedge clk) disable iff (rst)
    state == spi_pkg::st_idle && enable && master_mode |=> sck_out == cpol)
    else $error("sck not at idle level");
  a_half_period_floor: assert property (@(posedge clk) disable iff (rst)
    state == spi_pkg::st_master && tick |=> !tick)
    else $error("sck faster than clk/4");
  a_pulse_count: assert property (@(posedge clk) disable iff (rst)
    word_ends |-> toggles == {1'b0, last_edge})
    else $error("wrong number of sck edges in a word");
  a_select_held: assert property (@(posedge clk) disable iff (rst)
    word_begins ##1 (state == spi_pkg::st_master) |-> $stable(sel_reg))
    else $error("select changed during a word");
  a_start_selected: assert property (@(posedge clk) disable iff (rst)
    word_begins |-> ##1 (slave_select_out_n != 7'h7F))
    else $error("word began with no slave selected");
  a_slave_waits: assert property (@(posedge clk) disable iff (rst)
    ss_s2 && state != spi_pkg::st_slave |=> state != spi_pkg::st_slave)
    else $error("slave shifted while deselected");
  a_zero_fill: assert property (@(posedge clk) disable iff (rst)
    start_slave && !tx_valid |=> shift_tx == `SPI_ZERO_WORD)
    else $error("slave underrun not zero filled");
  a_dma_halt: assert property (@(posedge clk) disable iff (rst)
    dma_enable && dma_count == 16'h0000 && !dma_load |-> !start_master)
    else $error("master started after count expired");
  a_dma_event: assert property (@(posedge clk) disable iff (rst)
    dma_event |-> dma_count == 16'h0000 || $past(dma_load))
    else $error("dma event without count reaching zero");
  a_single_select: assert property (@(posedge clk) disable iff (rst)
    !broadcast ##1 !broadcast |-> $onehot0(sel_reg))
    else $error("several slaves selected outside broadcast");
  a_launch_hold: assert property (@(posedge clk) disable iff (rst)
    state == spi_pkg::st_master && !$past(launch) && !$past(load_word)
    |-> $stable(mosi_out))
    else $error("mosi moved off its launch edge");
  a_duplex_word: assert property (@(posedge clk) disable iff (rst)
    word_ends |=> word_event)
    else $error("completed word not reported");
endmodule : spi_port

// File: verif/spi_slave_model.sv
// behavioural spi slave that faces the port when it runs as master
`timescale 1ns/1ps
module spi_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic word16,
  input wire logic [15:0] tx_word,
  output logic miso,
  output logic [15:0] rx_word
);
  logic [15:0] sh;
  logic outb;
  initial begin
    sh = 16'h0000;
    outb = 1'b0;
    rx_word = 16'h0000;
  end
  // released line shows the inverse of the last bit, never a stale value
  assign miso = ss_n ? ~outb : outb;
  task automatic launch;
    outb = sh[15];
    sh = sh << 1;
  endtask : launch
  always @(negedge ss_n) begin
    sh = word16 ? tx_word : {tx_word[7:0], 8'h00};
    rx_word = 16'h0000;
    if (!cpha) launch();
  end
  // sample on one edge, launch on the other
  always @(sck) begin
    if (!ss_n) begin
      if ((sck != cpol) != cpha) rx_word = {rx_word[14:0], mosi};
      else launch();
    end
  end
endmodule : spi_slave_model

// File: verif/spi_port_master_slave_tb.sv
// self-checking testbench for the spi port
`timescale 1ns/1ps
module spi_port_master_slave_tb;
  logic clk = 0, rst = 1, enable = 0, master_mode = 1, word16 = 0;
  logic cpol = 0, cpha = 0, broadcast = 0, dma_enable = 0, dma_load = 0;
  logic tx_valid = 0, rx_ready = 0, tb_sck = 0, tb_mosi = 0, ss_in_n = 1;
  logic [15:0] baud_div = 16'h0004, dma_load_value = 16'h0000;
  logic [15:0] tx_data = 16'h0000, slave_word = 16'h0000;
  logic [6:0] select_mask = 7'h00;
  logic [15:0] dma_count, rx_data, slave_rx;
  logic [7:0] dma_page;
  logic [6:0] slave_select_out_n;
  logic tx_ready, rx_valid, word_event, dma_event, overrun_event, busy;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, slave_miso;
  logic sck_q = 0;
  // one shared line each for sck, mosi and miso
  wire logic sck_w = sck_oe ? sck_out : tb_sck;
  wire logic mosi_w = mosi_oe ? mosi_out : tb_mosi;
  wire logic miso_w = miso_oe ? miso_out : slave_miso;
  int checks = 0, n_mismatch = 0, cyc = 0, ev_word = 0, ev_dma = 0;
  int run = 0, last_half = 0, ev_ovr = 0;
  spi_port spi_port_i (.clk, .rst, .enable, .master_mode, .word16, .cpol,
    .cpha, .broadcast, .baud_div, .select_mask, .dma_enable, .dma_load,
    .dma_load_value, .dma_count, .dma_page, .tx_data, .tx_valid, .tx_ready,
    .rx_data, .rx_valid, .rx_ready, .word_event, .dma_event, .overrun_event,
    .busy, .sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w), .mosi_out,
    .mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe,
    .slave_select_in_n(ss_in_n), .slave_select_out_n);
  spi_slave_model spi_slave_model_i (.sck(sck_w), .mosi(mosi_w),
    .ss_n(slave_select_out_n[0]), .cpol, .cpha, .word16,
    .tx_word(slave_word), .miso(slave_miso), .rx_word(slave_rx));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // half period of the last sck level, in clk cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ev_word <= ev_word + int'(word_event);
    ev_dma <= ev_dma + int'(dma_event);
    ev_ovr <= ev_ovr + int'(overrun_event);
    sck_q <= sck_out;
    run <= (sck_out != sck_q) ? 1 : run + 1;
    if (sck_out != sck_q) last_half <= run;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic start_word(input logic [15:0] d);
    @(posedge clk);
    tx_data <= d;
    tx_valid <= 1'b1;
    do @(negedge clk); while (tx_ready !== 1'b1);
    @(posedge clk);
    tx_valid <= 1'b0;
  endtask : start_word
  task automatic pop_check(input logic [15:0] exp, input logic en);
    do @(negedge clk); while (rx_valid !== 1'b1);
    if (en) check(rx_data, exp);
    @(posedge clk);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
  endtask : pop_check
  task automatic expect_refused;
    int hits;
    hits = 0;
    @(posedge clk);
    tx_valid <= 1'b1;
    repeat (40) begin
      @(negedge clk);
      hits += int'(tx_ready === 1'b1);
    end
    @(posedge clk);
    tx_valid <= 1'b0;
    check(16'(hits), 16'h0000);
  endtask : expect_refused
  task automatic master_word(input logic [1:0] mode, input logic w16,
      input logic [15:0] d, input logic [15:0] s, input logic [15:0] bd,
      input logic chk_rx);
    logic [15:0] msk;
    int e0;
    msk = w16 ? 16'hFFFF : 16'h00FF;
    cpol <= mode[1];
    cpha <= mode[0];
    word16 <= w16;
    baud_div <= bd;
    slave_word <= s;
    repeat (2) @(posedge clk);
    select_mask <= 7'h01;
    repeat (4) @(posedge clk);
    e0 = ev_word;
    start_word(d);
    pop_check(s & msk, chk_rx);
    check(slave_rx & msk, d & msk);
    check(16'(ev_word - e0), 16'h0001);
    check({15'h0000, sck_w}, {15'h0000, mode[1]});
    check(16'(last_half), (bd < 16'h0002) ? 16'h0002 : bd);
    select_mask <= 7'h00;
    repeat (4) @(posedge clk);
    $display("master word mode %0d size16 %0b done", mode, w16);
  endtask : master_word
  task automatic select_test;
    select_mask <= 7'h06;
    repeat (4) @(posedge clk);
    check({9'h000, slave_select_out_n}, 16'h007D);
    broadcast <= 1'b1;
    repeat (4) @(posedge clk);
    check({9'h000, slave_select_out_n}, 16'h0079);
    broadcast <= 1'b0;
    select_mask <= 7'h00;
    repeat (4) @(posedge clk);
    $display("select test done");
  endtask : select_test
  task automatic dma_test;
    int e0;
    e0 = ev_dma;
    dma_load_value <= 16'h0002;
    dma_load <= 1'b1;
    @(posedge clk);
    dma_load <= 1'b0;
    dma_enable <= 1'b1;
    @(negedge clk);
    check(dma_count, 16'h0002);
    @(posedge clk);
    master_word(2'b00, 1'b0, 16'h005A, 16'h00C3, 16'h0004, 1'b1);
    master_word(2'b00, 1'b0, 16'h0066, 16'h0099, 16'h0004, 1'b1);
    check(dma_count, 16'h0000);
    check(16'(ev_dma - e0), 16'h0001);
    check({8'h00, dma_page}, 16'h0000);
    // a slave stays selected so only the spent count can refuse the word
    select_mask <= 7'h01;
    expect_refused();
    dma_enable <= 1'b0;
    select_mask <= 7'h00;
    $display("dma test done");
  endtask : dma_test
  // two words held while the reader stalls
  task automatic buffer_test;
    word16 <= 1'b1;
    baud_div <= 16'h0004;
    slave_word <= 16'h1111;
    repeat (2) @(posedge clk);
    select_mask <= 7'h01;
    repeat (4) @(posedge clk);
    start_word(16'h0101);
    start_word(16'h0202);
    do @(negedge clk); while (busy !== 1'b0);
    repeat (4) @(posedge clk);
    expect_refused();
    pop_check(16'h1111, 1'b1);
    pop_check(16'h0000, 1'b1);
    check(slave_rx, 16'h0202);
    check(16'(ev_ovr), 16'h0000);
    select_mask <= 7'h00;
    repeat (4) @(posedge clk);
    $display("buffer test done");
  endtask : buffer_test
  task automatic slave_test;
    logic [7:0] got;
    logic [7:0] pat;
    got = 8'hFF;
    pat = 8'hA5;
    master_mode <= 1'b0;
    word16 <= 1'b0;
    cpol <= 1'b0;
    cpha <= 1'b0;
    tb_mosi <= 1'b1;
    repeat (16) begin
      repeat (8) @(posedge clk);
      tb_sck <= ~tb_sck;
    end
    repeat (8) @(posedge clk);
    @(negedge clk);
    check({15'h0000, rx_valid}, 16'h0000);
    @(posedge clk);
    ss_in_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      tb_mosi <= pat[i];
      repeat (7) @(posedge clk);
      @(negedge clk);
      got[i] = miso_w;
      @(posedge clk);
      tb_sck <= 1'b1;
      repeat (8) @(posedge clk);
      tb_sck <= 1'b0;
    end
    repeat (8) @(posedge clk);
    ss_in_n <= 1'b1;
    pop_check(16'h00A5, 1'b1);
    check({8'h00, got}, 16'h0000);
    $display("slave test done");
  endtask : slave_test
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    enable <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      master_word(m[1:0], m[2], 16'(16'hA5C3 + m * 16'h0101),
        16'(16'h3C5A + m), 16'h0004, 1'b1);
    end
    master_word(2'b00, 1'b0, 16'h0081, 16'h0042, 16'h0001, 1'b0);
    select_test();
    dma_test();
    buffer_test();
    slave_test();
    tally_and_finish();
  end
endmodule : spi_port_master_slave_tb
